// file: tzc_host.sv
/* Host controller model that writes and reads the register port.
   Assumes the same clock as the bank and one byte per access. */
`timescale 1ns/100ps
module tzc_host (
    // Clock and read data
    input  wire logic       clock,
    input  wire logic [7:0] reg_rd_data,
    // Register port
    output logic            reg_wr_en,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wr_data
);
    initial begin
        reg_wr_en = 1'b0;
        reg_addr = 8'h00;
        reg_wr_data = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1 reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wr_data = d;
        @(posedge clock);
        #1 reg_wr_en = 1'b0;
        // Stale data is inverted so a late sample cannot pass by luck.
        reg_wr_data = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        #1 reg_addr = a;
        @(posedge clock);
        #1 d = reg_rd_data;
    endtask
endmodule

// file: tzc_pkg.sv
/*
 * Package for the thermal and temperature zone control register bank.
 * Holds register offsets, field positions, reset values and action codes.
 * Assumes a byte-wide register port driven by the serial bus front end.
 */
package tzc_pkg;

    localparam logic [7:0] THERM_CTRL_ADDR = 8'h16;
    localparam logic [7:0] ZONE_CTRL_ADDR  = 8'h17;

    localparam logic [7:0] THERM_CTRL_RESET = 8'hc0;
    localparam logic [7:0] ZONE_CTRL_RESET  = 8'h7a;

    // Field positions in the thermal threshold register.
    localparam int TREG_MSB    = 7;
    localparam int TREG_LSB    = 6;
    localparam int TSHUT_MSB   = 5;
    localparam int TSHUT_LSB   = 4;
    localparam int MAIN_PD_BIT = 3;
    localparam int AUX1_PD_BIT = 2;
    localparam int AUX2_PD_BIT = 1;

    // Field positions in the zone charge register.
    localparam int WVOLT_MSB = 7;
    localparam int WVOLT_LSB = 5;
    localparam int WCURR_MSB = 4;
    localparam int WCURR_LSB = 3;
    localparam int CCURR_MSB = 2;
    localparam int CCURR_LSB = 1;

    // Charge voltage target in mV and charge current target in mA.
    localparam int VOLT_W = 16;
    localparam int CURR_W = 16;

    // Voltage reductions in mV for warm-zone codes 1 to 6.
    localparam logic [15:0] VDROP_1 = 16'h0320;
    localparam logic [15:0] VDROP_2 = 16'h0258;
    localparam logic [15:0] VDROP_3 = 16'h0190;
    localparam logic [15:0] VDROP_4 = 16'h0190;
    localparam logic [15:0] VDROP_5 = 16'h00c8;
    localparam logic [15:0] VDROP_6 = 16'h0064;

    localparam logic [2:0] VACT_SUSPEND = 3'h0;
    localparam logic [1:0] IACT_SUSPEND = 2'h0;
    localparam logic [1:0] IACT_PCT20   = 2'h1;
    localparam logic [1:0] IACT_PCT40   = 2'h2;

    // Percent scaling as multiply then divide by 100.
    localparam logic [7:0] PCT20   = 8'h14;
    localparam logic [7:0] PCT40   = 8'h28;
    localparam logic [7:0] PCT_DIV = 8'h64;

    typedef enum logic [1:0] {
        ZONE_NORMAL,
        ZONE_WARM,
        ZONE_COOL
    } tzc_zone_type;

    typedef struct packed {
        logic [1:0] die_temp_regulation_threshold;
        logic [1:0] overtemp_shutdown_threshold;
        logic       main_input_pulldown_enable;
        logic       aux_input1_pulldown_enable;
        logic       aux_input2_pulldown_enable;
    } tzc_therm_type;

    typedef struct packed {
        logic [VOLT_W-1:0] charge_voltage_target;
        logic [CURR_W-1:0] charge_current_target;
        logic              charge_suspend;
    } tzc_target_type;

endpackage

// file: tzc_regs.sv
/*
 * Thermal threshold / pull-down register and temperature zone charge register,
 * plus the zone-dependent adjustment of the charge targets.
 * Assumes the serial bus front end presents single-cycle write strobes and a
 * read address, and that zone detection supplies the current battery zone.
 */
`timescale 1ns/100ps
// Operation
// - Bits 7-6 of the thermal register select die regulation at 60/80/100/120 C, default 3.
// - Bits 5-4 select thermal shutdown at 150/130/120/85 C, default 0.
// - Bit 3 enables the 6 kilohm main input pull-down, default off.
// - Bit 2 enables the first auxiliary input pull-down, default off.
// - Bit 1 enables the second auxiliary input pull-down, default off.
// - The pull-down bits reset only on a register reset, not on watchdog expiry.
// - Threshold fields and all zone fields reset on watchdog expiry or register reset.
// - Bits 7-5 of the zone register set the warm voltage action, default 3.
// - Bits 4-3 set the warm current action, default 3.
// - Bits 2-1 set the cool current action with the same codes, default 1.
module tzc_regs (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  srst,
    // Register port
    input  wire logic                  reg_wr_en,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wr_data,
    output logic      [7:0]            reg_rd_data,
    // Reset sources
    input  wire logic                  register_reset,
    input  wire logic                  watchdog_expired,
    // Zone and base targets
    input  wire logic                  zone_warm,
    input  wire logic                  zone_cool,
    input  wire logic [15:0]           base_voltage_target,
    input  wire logic [15:0]           base_current_target,
    // Control outputs
    output tzc_pkg::tzc_therm_type     therm_ctrl,
    output logic      [2:0]            warm_zone_voltage_action,
    output logic      [1:0]            warm_zone_current_action,
    output logic      [1:0]            cool_zone_current_action,
    output tzc_pkg::tzc_target_type    charge_target
);

    logic [7:0]                 therm_q;
    logic [3:0]                 thr_q;
    logic [2:0]                 pd_q;
    logic [7:0]                 zone_q;
    logic [7:0]                 rd_d;
    logic                       wr_therm;
    logic                       wr_zone;
    logic                       soft_reset;
    tzc_pkg::tzc_zone_type      zone;
    tzc_pkg::tzc_target_type    target_d;
    logic [23:0]                scaled;

    assign wr_therm   = reg_wr_en && (reg_addr == tzc_pkg::THERM_CTRL_ADDR);
    assign wr_zone    = reg_wr_en && (reg_addr == tzc_pkg::ZONE_CTRL_ADDR);
    assign soft_reset = register_reset || watchdog_expired;

    // The two field groups live in separate flops so each has exactly one writer.
    assign therm_q = {thr_q, pd_q, 1'b0};

    // Threshold fields follow both reset sources.
    always_ff @(posedge clock) begin
        if (srst || soft_reset) begin
            thr_q <= tzc_pkg::THERM_CTRL_RESET[tzc_pkg::TREG_MSB:tzc_pkg::TSHUT_LSB];
        end else if (wr_therm) begin
            thr_q <= reg_wr_data[tzc_pkg::TREG_MSB:tzc_pkg::TSHUT_LSB];
        end
    end

    // Pull-downs survive a watchdog expiry so a stuck host cannot drop them.
    always_ff @(posedge clock) begin
        if (srst || register_reset) begin
            pd_q <= tzc_pkg::THERM_CTRL_RESET[tzc_pkg::MAIN_PD_BIT:tzc_pkg::AUX2_PD_BIT];
        end else if (wr_therm) begin
            pd_q[2] <= reg_wr_data[tzc_pkg::MAIN_PD_BIT];
            pd_q[1] <= reg_wr_data[tzc_pkg::AUX1_PD_BIT];
            pd_q[0] <= reg_wr_data[tzc_pkg::AUX2_PD_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (srst || soft_reset) begin
            zone_q <= tzc_pkg::ZONE_CTRL_RESET;
        end else if (wr_zone) begin
            zone_q <= {reg_wr_data[7:1], 1'b0};
        end
    end

    // Register read-back; unmapped addresses read zero.
    always_comb begin
        rd_d = 8'h00;
        if (reg_addr == tzc_pkg::THERM_CTRL_ADDR) begin
            rd_d = {therm_q[7:1], 1'b0};
        end else if (reg_addr == tzc_pkg::ZONE_CTRL_ADDR) begin
            rd_d = {zone_q[7:1], 1'b0};
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            reg_rd_data <= 8'h00;
        end else begin
            reg_rd_data <= rd_d;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            therm_ctrl <= tzc_pkg::tzc_therm_type'(tzc_pkg::THERM_CTRL_RESET[7:1]);
            warm_zone_voltage_action <= tzc_pkg::ZONE_CTRL_RESET[7:5];
            warm_zone_current_action <= tzc_pkg::ZONE_CTRL_RESET[4:3];
            cool_zone_current_action <= tzc_pkg::ZONE_CTRL_RESET[2:1];
        end else begin
            therm_ctrl <= tzc_pkg::tzc_therm_type'(therm_q[7:1]);
            warm_zone_voltage_action <= zone_q[tzc_pkg::WVOLT_MSB:tzc_pkg::WVOLT_LSB];
            warm_zone_current_action <= zone_q[tzc_pkg::WCURR_MSB:tzc_pkg::WCURR_LSB];
            cool_zone_current_action <= zone_q[tzc_pkg::CCURR_MSB:tzc_pkg::CCURR_LSB];
        end
    end

    // Warm takes priority should zone detection ever report both.
    always_comb begin
        if (zone_warm) begin
            zone = tzc_pkg::ZONE_WARM;
        end else if (zone_cool) begin
            zone = tzc_pkg::ZONE_COOL;
        end else begin
            zone = tzc_pkg::ZONE_NORMAL;
        end
    end

    function automatic logic [15:0] scale_current(input logic [1:0] act,
                                                  input logic [15:0] base);
        logic [23:0] prod;
        prod = 24'h000000;
        case (act)
            tzc_pkg::IACT_PCT20: prod = (base * tzc_pkg::PCT20) / tzc_pkg::PCT_DIV;
            tzc_pkg::IACT_PCT40: prod = (base * tzc_pkg::PCT40) / tzc_pkg::PCT_DIV;
            default:             prod = {8'h00, base};
        endcase
        return prod[15:0];
    endfunction

    function automatic logic [15:0] drop_voltage(input logic [2:0] act,
                                                 input logic [15:0] base);
        logic [15:0] drop;
        drop = 16'h0000;
        case (act)
            3'h1:    drop = tzc_pkg::VDROP_1;
            3'h2:    drop = tzc_pkg::VDROP_2;
            3'h3:    drop = tzc_pkg::VDROP_3;
            3'h4:    drop = tzc_pkg::VDROP_4;
            3'h5:    drop = tzc_pkg::VDROP_5;
            3'h6:    drop = tzc_pkg::VDROP_6;
            default: drop = 16'h0000;
        endcase
        // Saturate at zero rather than wrapping on a tiny base target.
        return (base > drop) ? 16'(base - drop) : 16'h0000;
    endfunction

    always_comb begin
        scaled = 24'h000000;
        target_d.charge_voltage_target = base_voltage_target;
        target_d.charge_current_target = base_current_target;
        target_d.charge_suspend        = 1'b0;
        case (zone)
            tzc_pkg::ZONE_WARM: begin
                target_d.charge_voltage_target =
                    drop_voltage(zone_q[7:5], base_voltage_target);
                target_d.charge_current_target =
                    scale_current(zone_q[4:3], base_current_target);
                target_d.charge_suspend = (zone_q[7:5] == tzc_pkg::VACT_SUSPEND) ||
                                          (zone_q[4:3] == tzc_pkg::IACT_SUSPEND);
            end
            tzc_pkg::ZONE_COOL: begin
                target_d.charge_current_target =
                    scale_current(zone_q[2:1], base_current_target);
                target_d.charge_suspend = (zone_q[2:1] == tzc_pkg::IACT_SUSPEND);
            end
            default: begin
                scaled = 24'h000000;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            charge_target <= '0;
        end else begin
            charge_target <= target_d;
        end
    end

endmodule

// file: tzc_regs_asserts.sv
/* Concurrent checks on the thermal and zone control register bank.
   Assumes it is bound to tzc_regs and sees only that module's ports. */
`timescale 1ns/100ps
module tzc_regs_asserts (
    // Clock, reset and register port
    input wire logic        clock, srst, reg_wr_en, register_reset, watchdog_expired,
    input wire logic [7:0]  reg_addr, reg_wr_data, reg_rd_data,
    // Zone side
    input wire logic        zone_warm, zone_cool,
    input wire logic [15:0] base_voltage_target, base_current_target,
    input wire logic [2:0]  warm_zone_voltage_action,
    input wire logic [1:0]  warm_zone_current_action, cool_zone_current_action,
    input tzc_pkg::tzc_therm_type  therm_ctrl,
    input tzc_pkg::tzc_target_type charge_target
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    wire       quiet = !register_reset && !watchdog_expired;
    wire [6:0] acts  = {warm_zone_voltage_action, warm_zone_current_action,
                        cool_zone_current_action};
    // A write that no reset or second write to the same place disturbs.
    sequence clean_wr(a);
        reg_wr_en && reg_addr == a && quiet ##1 quiet && !(reg_wr_en && reg_addr == a);
    endsequence
    a_therm_fields: assert property (clean_wr(8'h16) |-> ##1
        therm_ctrl[6:3] == $past(reg_wr_data[7:4], 2)) else $error("threshold field wrong");
    a_pulldown_fields: assert property (clean_wr(8'h16) |-> ##1
        therm_ctrl[2:0] == $past(reg_wr_data[3:1], 2)) else $error("pull-down bit wrong");
    a_zone_fields: assert property (clean_wr(8'h17) |-> ##1
        acts == $past(reg_wr_data[7:1], 2)) else $error("zone field wrong");
    a_wdog_keeps_pd: assert property (!reg_wr_en && !register_reset ##1
        watchdog_expired && !register_reset && !reg_wr_en ##1 !reg_wr_en && !register_reset
        |-> ##1 therm_ctrl[2:0] == $past(therm_ctrl[2:0], 2)) else $error("pull-down lost");
    a_wdog_defaults: assert property (watchdog_expired ##1 !reg_wr_en |-> ##1
        therm_ctrl[6:3] == 4'hc && acts == 7'h3d) else $error("watchdog default wrong");
    a_regrst_defaults: assert property (register_reset ##1 !reg_wr_en |-> ##1
        therm_ctrl == 7'h60 && acts == 7'h3d) else $error("reset default wrong");
    a_read_therm: assert property (reg_addr == 8'h16 |=>
        reg_rd_data == {therm_ctrl, 1'b0}) else $error("thermal read wrong");
    a_read_zone: assert property (reg_addr == 8'h17 |=>
        reg_rd_data == {acts, 1'b0}) else $error("zone read wrong");
    a_pass_normal: assert property (!zone_warm && !zone_cool |=> charge_target ==
        {$past(base_voltage_target), $past(base_current_target), 1'b0}) else $error("normal");
    a_warm_voltage: assert property (zone_warm && base_voltage_target >= 16'h0320 ##1
        warm_zone_voltage_action == 3'h1 |-> charge_target[32:17] ==
        $past(base_voltage_target) - 16'h0320) else $error("warm voltage wrong");
    a_warm_suspend: assert property (zone_warm ##1 warm_zone_current_action == 2'h0
        |-> charge_target[0]) else $error("warm suspend missing");
    a_cool_current: assert property (zone_cool && !zone_warm ##1
        cool_zone_current_action == 2'h1 |-> charge_target[16:1] ==
        16'(32'($past(base_current_target)) * 20 / 100)) else $error("cool current wrong");
endmodule
bind tzc_regs tzc_regs_asserts chk (.clock, .srst, .reg_wr_en, .register_reset,
    .watchdog_expired, .reg_addr, .reg_wr_data, .reg_rd_data, .zone_warm, .zone_cool,
    .base_voltage_target, .base_current_target, .warm_zone_voltage_action,
    .warm_zone_current_action, .cool_zone_current_action, .therm_ctrl, .charge_target);

// file: tzc_regs_bench.sv
/* Self-checking bench for the thermal and zone control register bank.
   Assumes the host model drives the register port and the checker is bound. */
`timescale 1ns/100ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin failures++; \
    $display("BAD %s exp %h got %h", n, e, a); end end
module tzc_regs_bench;
    logic clock, srst, register_reset, watchdog_expired, zone_warm, zone_cool, reg_wr_en;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data, rd;
    logic [15:0] base_voltage_target, base_current_target;
    logic [2:0] warm_zone_voltage_action;
    logic [1:0] warm_zone_current_action, cool_zone_current_action;
    tzc_pkg::tzc_therm_type therm_ctrl;
    tzc_pkg::tzc_target_type charge_target;
    logic [15:0] drop [8] = '{16'h0000, 16'h0320, 16'h0258, 16'h0190, 16'h0190, 16'h00c8,
                              16'h0064, 16'h0000};
    logic [15:0] cur [4] = '{16'h0000, 16'h00c8, 16'h0190, 16'h03e8};
    int failures = 0;
    int checks = 0;
    tzc_host host (.clock, .reg_rd_data, .reg_wr_en, .reg_addr, .reg_wr_data);
    tzc_regs uut (.clock, .srst, .reg_wr_en, .reg_addr, .reg_wr_data, .reg_rd_data,
        .register_reset, .watchdog_expired, .zone_warm, .zone_cool, .base_voltage_target,
        .base_current_target, .therm_ctrl, .warm_zone_voltage_action,
        .warm_zone_current_action, .cool_zone_current_action, .charge_target);
    task automatic results();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, rd);
        `CHK("read", e, rd)
    endtask
    task automatic pulse(input logic [1:0] sel);
        @(posedge clock);
        #1 {register_reset, watchdog_expired} = sel;
        @(posedge clock);
        #1 {register_reset, watchdog_expired} = 2'b00;
    endtask
    task automatic t_defaults();
        rdchk(8'h16, 8'hc0);
        rdchk(8'h17, 8'h7a);
        rdchk(8'h18, 8'h00);
    endtask
    // Every thermal bit set and the zone register cleared, then the two reset sources, which treat pull-downs differently.
    task automatic t_resets();
        host.wr(8'h16, 8'hff);
        host.wr(8'h17, 8'h01);
        rdchk(8'h16, 8'hfe);
        rdchk(8'h17, 8'h00);
        `CHK("therm", 7'h7f, therm_ctrl)
        pulse(2'b01);
        rdchk(8'h16, 8'hce);
        rdchk(8'h17, 8'h7a);
        pulse(2'b10);
        rdchk(8'h16, 8'hc0);
    endtask
    task automatic t_voltage();
        zone_warm = 1'b1;
        for (int c = 0; c < 8; c++) begin
            host.wr(8'h17, {c[2:0], 5'h1a});
            repeat (2) @(posedge clock);
            #1 `CHK("vsus", c == 0, charge_target.charge_suspend)
            if (c > 0) `CHK("volt", 16'h1068 - drop[c], charge_target[32:17])
        end
    endtask
    task automatic t_current();
        for (int z = 0; z < 2; z++) begin
            zone_warm = (z == 0);
            zone_cool = (z == 1);
            for (int c = 0; c < 4; c++) begin
                host.wr(8'h17, (z == 0) ? {3'h7, c[1:0], 3'h2} : {5'h1f, c[1:0], 1'b0});
                repeat (2) @(posedge clock);
                #1 `CHK("isus", c == 0, charge_target.charge_suspend)
                if (c > 0) `CHK("curr", cur[c], charge_target[16:1])
            end
        end
    endtask
    task automatic t_normal();
        zone_cool = 1'b0;
        host.wr(8'h17, 8'h00);
        repeat (2) @(posedge clock);
        #1 `CHK("norm", {16'h1068, 16'h03e8, 1'b0}, charge_target)
    endtask
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        {srst, register_reset, watchdog_expired, zone_warm, zone_cool} = 5'h10;
        base_voltage_target = 16'h1068;
        base_current_target = 16'h03e8;
        repeat (12) @(posedge clock);
        #1 srst = 1'b0;
        t_defaults();
        t_resets();
        t_voltage();
        t_current();
        t_normal();
        results();
    end
    initial begin
        #20000;
        failures++;
        results();
    end
endmodule
